// File: gtc_pkg.sv
package gtc_pkg;

  // register bus geometry
  localparam int          GTC_ADDR_W     = 3;
  localparam int          GTC_DATA_W     = 8;

  // register byte offsets
  localparam logic [2:0]  GTC_ADDR_CNT_LO = 3'h0;
  localparam logic [2:0]  GTC_ADDR_CNT_HI = 3'h1;
  localparam logic [2:0]  GTC_ADDR_CTL    = 3'h2;
  localparam logic [2:0]  GTC_ADDR_GATE   = 3'h3;
  localparam logic [2:0]  GTC_ADDR_STAT   = 3'h4;

  // clock select codes
  localparam logic [1:0]  GTC_CS_INSTR   = 2'h0;
  localparam logic [1:0]  GTC_CS_SYS     = 2'h1;
  localparam logic [1:0]  GTC_CS_EXT     = 2'h2;
  localparam logic [1:0]  GTC_CS_CAP     = 2'h3;

  // status and gate field positions
  localparam int          GTC_STAT_OVF_BIT = 0;
  localparam int          GTC_STAT_OSC_BIT = 1;
  localparam int          GTC_STAT_ARM_BIT = 2;
  localparam int          GTC_GATE_LVL_BIT = 0;

  // reset values and counts
  localparam logic [7:0]  GTC_CTL_RESET  = 8'h00;
  localparam logic [7:0]  GTC_GATE_RESET = 8'h00;
  localparam logic [15:0] GTC_CNT_RESET  = 16'h0000;
  localparam logic [15:0] GTC_CNT_MAX    = 16'hffff;
  localparam logic [15:0] GTC_CNT_ONE    = 16'h0001;
  localparam logic [2:0]  GTC_PRE_RESET  = 3'h0;
  localparam logic [1:0]  GTC_INSTR_LAST = 2'h3;
  localparam logic [1:0]  GTC_INSTR_ONE  = 2'h1;

  // timer control register layout
  typedef struct packed {
    logic [1:0] clock_select;
    logic [1:0] prescale_select;
    logic       crystal_osc_enable;
    logic       sync_disable;
    logic       spare;
    logic       run_enable;
  } gtc_ctl_t;

  // gate control register layout
  typedef struct packed {
    logic       gate_qualify_enable;
    logic [6:0] spare;
  } gtc_gate_t;

endpackage

// File: gtc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module gtc_prescaler
  import gtc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       tick,
  input  wire logic [1:0] ratio,
  output logic            out,
  output logic [2:0]      count
);

  logic [2:0] count_q;
  logic       full;

  // terminal mask for divide by 1, 2, 4 or 8
  function automatic logic [2:0] ratio_mask(input logic [1:0] r);
    case (r)
      2'h0:    ratio_mask = 3'h0;
      2'h1:    ratio_mask = 3'h1;
      2'h2:    ratio_mask = 3'h3;
      default: ratio_mask = 3'h7;
    endcase
  endfunction

  assign full  = (count_q & ratio_mask(ratio)) == ratio_mask(ratio);
  assign out   = tick & full;
  assign count = count_q;

  // hidden divider, cleared by count writes
  always_ff @(posedge sys_clk)
  begin
    if (rst || clear)
      count_q <= GTC_PRE_RESET;
    else if (tick && full)
      count_q <= GTC_PRE_RESET;
    else if (tick)
      count_q <= count_q + 3'h1;
  end

endmodule

`default_nettype wire

// File: gtc_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none

module gtc_edge_detect
  import gtc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic raw_in,
  input  wire logic sync_en,
  output logic      rise,
  output logic      fall
);

  logic meta_q;
  logic sync_q;
  logic direct_q;
  logic prev_q;
  logic level;

  // two-stage path for synchronised counting
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  // single-stage path for unsynchronised counting
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      direct_q <= 1'b0;
    else
      direct_q <= raw_in;
  end

  // one-count slip
  // path choice shifts edge timing, can drop or add one
  assign level = sync_en ? sync_q : direct_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      prev_q <= 1'b0;
    else
      prev_q <= level;
  end

  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;

endmodule

`default_nettype wire

// File: gtc_timer.sv
// Functional notes
// - The 16-bit count is a low and high byte, each replaced at once on write.
// - An internal source makes the block a timer stepping per prescaled tick.
// - Run-enable 0 stops it; with gate qualify set it counts only when gated.
// - Clock select picks system, instruction, cap-sense, pin or crystal.
// - External sources count on each rising edge while enabled.
// - External sources are either synchronised or counted unsynchronised.
// - A falling edge must be seen before the first counted rising edge.
// - The selected clock is divided by 1, 2, 4 or 8 before counting.
// - The divider is hidden from software and cleared by any count write.
// - The crystal oscillator runs while enabled, including in sleep.
// - Sync-disable set counts external edges without synchronising.
// - Unsynchronised external counting runs in sleep and wakes on wrap.
// - Changing sync mode may drop or add a single increment.
// - Byte reads return a clean value while external counting runs.
// - When gated, the count holds while the gate input is low.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module gtc_timer
  import gtc_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic [GTC_ADDR_W-1:0] addr,
  input  wire logic [GTC_DATA_W-1:0] wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [GTC_DATA_W-1:0] rdata,
  input  wire logic                  gate_input,
  input  wire logic                  ext_clock_pin,
  input  wire logic                  cap_sense_osc,
  input  wire logic                  crystal_in_pin,
  output logic                       crystal_out_pin,
  input  wire logic                  sleep_mode,
  output logic                       overflow_flag,
  output logic                       wake_request
);

  gtc_ctl_t    ctl_q;
  gtc_gate_t   gate_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [1:0]  instr_div_q;
  logic        instr_tick;
  logic        osc_out_q;
  logic        ovf_q;
  logic        wake_q;
  logic        armed_q;
  logic [7:0]  rdata_q;
  logic        wr_lo;
  logic        wr_hi;
  logic        cnt_wr;
  logic        ext_sel;
  logic        ext_raw;
  logic        ext_rise;
  logic        ext_fall;
  logic        running;
  logic        clocks_alive;
  logic        src_tick;
  logic        pre_tick;
  logic        inc;
  logic        wrap;
  logic [2:0]  pre_count;

  // address match used by several decoders
  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    hit = (a == off);
  endfunction

  // write strobes toward the count bytes
  assign wr_lo  = wr && hit(addr, GTC_ADDR_CNT_LO);
  assign wr_hi  = wr && hit(addr, GTC_ADDR_CNT_HI);
  assign cnt_wr = wr_lo || wr_hi;

  // timer control register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ctl_q <= gtc_ctl_t'(GTC_CTL_RESET);
    else if (wr && hit(addr, GTC_ADDR_CTL))
      ctl_q <= gtc_ctl_t'(wdata);
  end

  // gate control register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      gate_q <= gtc_gate_t'(GTC_GATE_RESET);
    else if (wr && hit(addr, GTC_ADDR_GATE))
      gate_q <= gtc_gate_t'(wdata);
  end

  // instruction clock, one tick in four system cycles
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      instr_div_q <= 2'h0;
    else
      instr_div_q <= instr_div_q + GTC_INSTR_ONE;
  end

  assign instr_tick = (instr_div_q == GTC_INSTR_LAST);

  // crystal amplifier
  // inverting stage, kept alive through sleep
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      osc_out_q <= 1'b0;
    else
      osc_out_q <= ctl_q.crystal_osc_enable & ~crystal_in_pin;
  end

  assign crystal_out_pin = osc_out_q;

  // external source mux
  // pin or crystal share one code, oscillator enable decides
  always_comb
  begin
    case (ctl_q.clock_select)
      GTC_CS_CAP: ext_raw = cap_sense_osc;
      GTC_CS_EXT: ext_raw = ctl_q.crystal_osc_enable ? crystal_in_pin
                                                     : ext_clock_pin;
      default:    ext_raw = 1'b0;
    endcase
  end

  assign ext_sel = ctl_q.clock_select[1];

  gtc_edge_detect u_edge (
    .sys_clk (sys_clk),
    .rst     (rst),
    .raw_in  (ext_raw),
    .sync_en (~ctl_q.sync_disable),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );

  // falling edge arming
  // write or disable forgets any edge seen before
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      armed_q <= 1'b0;
    else if (cnt_wr || !ctl_q.run_enable)
      armed_q <= 1'b0;
    else if (ext_fall)
      armed_q <= 1'b1;
  end

  always_comb
  begin
    case (ctl_q.clock_select)
      GTC_CS_SYS:   src_tick = 1'b1;
      GTC_CS_INSTR: src_tick = instr_tick;
      default:      src_tick = ext_rise & armed_q;
    endcase
  end

  assign running = ctl_q.run_enable &
                   (~gate_q.gate_qualify_enable | gate_input);

  // only unsynchronised external counting survives sleep
  assign clocks_alive = ~sleep_mode | (ext_sel & ctl_q.sync_disable);

  // a count write owns the cycle, no tick competes with it
  assign pre_tick = src_tick & running & clocks_alive & ~cnt_wr;

  // prescaler, cleared on count write or stop
  gtc_prescaler u_pre (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clear   (cnt_wr | ~ctl_q.run_enable),
    .tick    (pre_tick),
    .ratio   (ctl_q.prescale_select),
    .out     (inc),
    .count   (pre_count)
  );

  // byte writes replace part of the live count
  always_comb
  begin
    count_d = count_q;
    if (wr_lo)
      count_d = {count_q[15:8], wdata};
    else if (wr_hi)
      count_d = {wdata, count_q[7:0]};
    else if (inc)
      count_d = count_q + GTC_CNT_ONE;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      count_q <= GTC_CNT_RESET;
    else
      count_q <= count_d;
  end

  assign wrap = inc && (count_q == GTC_CNT_MAX);

  // sticky overflow flag
  // write one to clear; a wrap in the same cycle wins
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ovf_q <= 1'b0;
    else if (wrap)
      ovf_q <= 1'b1;
    else if (wr && hit(addr, GTC_ADDR_STAT) && wdata[GTC_STAT_OVF_BIT])
      ovf_q <= 1'b0;
  end

  // wake pulse on a wrap during sleep
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      wake_q <= 1'b0;
    else
      wake_q <= wrap & sleep_mode;
  end

  assign overflow_flag = ovf_q;
  assign wake_request  = wake_q;

  // read capture
  // count bytes come from one clocked copy, never mid-change
  always_ff @(posedge sys_clk)
  begin
    if (rst || !rd)
      rdata_q <= 8'h00;
    else
    begin
      case (addr)
        GTC_ADDR_CNT_LO: rdata_q <= count_q[7:0];
        GTC_ADDR_CNT_HI: rdata_q <= count_q[15:8];
        GTC_ADDR_CTL:    rdata_q <= ctl_q;
        GTC_ADDR_GATE:   rdata_q <= {gate_q.gate_qualify_enable, 6'h00,
                                     gate_input};
        GTC_ADDR_STAT:   rdata_q <= {5'h00, armed_q,
                                     ctl_q.crystal_osc_enable, ovf_q};
        default:         rdata_q <= 8'h00;
      endcase
    end
  end

  assign rdata = rdata_q;

  // checks on the count, divider and flags
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_write_low;
    wr_lo |=> count_q[7:0] == $past(wdata);
  endproperty
  a_write_low: assert property (p_write_low)
    else $error("low byte write not taken");

  property p_write_high;
    wr_hi |=> (count_q[15:8] == $past(wdata)) &&
              (count_q[7:0] == $past(count_q[7:0]));
  endproperty
  a_write_high: assert property (p_write_high)
    else $error("high byte write not taken");

  property p_sys_rate;
    (ctl_q.run_enable && !gate_q.gate_qualify_enable &&
     ctl_q.clock_select == GTC_CS_SYS && ctl_q.prescale_select == 2'h0 &&
     !sleep_mode && !cnt_wr) |=> count_q == $past(count_q) + GTC_CNT_ONE;
  endproperty
  a_sys_rate: assert property (p_sys_rate)
    else $error("system clock source did not step once");

  property p_off_hold;
    (!ctl_q.run_enable && !cnt_wr) |=> $stable(count_q);
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("count moved while stopped");

  property p_gate_hold;
    (gate_q.gate_qualify_enable && !gate_input && !cnt_wr)
      |=> $stable(count_q);
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("count moved with gate closed");

  property p_unarmed_hold;
    (ext_sel && !armed_q && !cnt_wr) |=> $stable(count_q);
  endproperty
  a_unarmed_hold: assert property (p_unarmed_hold)
    else $error("external count before falling edge");

  property p_write_disarms;
    cnt_wr |=> !armed_q;
  endproperty
  a_write_disarms: assert property (p_write_disarms)
    else $error("count write left edge armed");

  property p_pre_clear;
    cnt_wr |=> pre_count == GTC_PRE_RESET;
  endproperty
  a_pre_clear: assert property (p_pre_clear)
    else $error("prescaler not cleared by count write");

  property p_div2;
    (inc && ctl_q.prescale_select == 2'h1 && !wr) |=> !inc;
  endproperty
  a_div2: assert property (p_div2)
    else $error("divide by two stepped twice in a row");

  property p_osc_run;
    ctl_q.crystal_osc_enable |=> crystal_out_pin == !$past(crystal_in_pin);
  endproperty
  a_osc_run: assert property (p_osc_run)
    else $error("crystal amplifier not driving");

  property p_sleep_freeze;
    (sleep_mode && !(ext_sel && ctl_q.sync_disable) && !cnt_wr)
      |=> $stable(count_q);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze)
    else $error("synchronous count moved in sleep");

  property p_wake;
    (wrap && sleep_mode) |=> wake_request ##1 !wake_request;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wrap in sleep gave no single wake pulse");

  property p_overflow;
    wrap |=> overflow_flag && (count_q == GTC_CNT_RESET);
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("wrap did not set overflow flag");

endmodule

`default_nettype wire

// File: gtc_ext_src.sv
`timescale 1ns/1ps
`default_nettype none

// far-side clock source: a pin or crystal that stands still between bursts
module gtc_ext_src (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] cycles,
  input  wire logic       idle_hi,
  output logic            pin,
  output logic            busy
);
  logic [8:0] left_q;
  logic [1:0] ph_q;

  // burst of full periods, three cycles per level
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      left_q <= 9'h000;
      ph_q   <= 2'h0;
      pin    <= 1'b0;
    end
    else if (start && left_q == 9'h000)
    begin
      left_q <= {cycles, 1'b0};
      ph_q   <= 2'h0;
    end
    else if (left_q != 9'h000)
    begin
      if (ph_q == 2'h2)
      begin
        ph_q   <= 2'h0;
        pin    <= ~pin;
        left_q <= left_q - 9'h001;
      end
      else
        ph_q <= ph_q + 2'h1;
    end
    else
      pin <= idle_hi;
  end

  // burst in progress
  assign busy = (left_q != 9'h000);
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("wrong value at %0t: got %h want %h", $time, g, e); \
    end \
  end

module tb_top
  import gtc_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       gate_input = 1'b0;
  logic       sleep_mode = 1'b0;
  logic       idle_hi = 1'b0;
  logic [7:0] cyc = 8'h00;
  logic [2:0] src_start = 3'h0;
  logic [7:0] rdata;
  logic [2:0] src_pin;
  logic [2:0] src_busy;
  logic       crystal_out_pin;
  logic       overflow_flag;
  logic       wake_request;
  int         n_fail = 0;
  int         total_checks = 0;
  int         n_wake = 0;

  // 250 MHz system clock
  always #2 sys_clk = ~sys_clk;

  gtc_timer gtc_timer_inst (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .gate_input(gate_input),
    .ext_clock_pin(src_pin[0]), .cap_sense_osc(src_pin[2]),
    .crystal_in_pin(src_pin[1]), .crystal_out_pin(crystal_out_pin),
    .sleep_mode(sleep_mode), .overflow_flag(overflow_flag),
    .wake_request(wake_request));

  // pin, crystal and cap-sense sources on the far side
  gtc_ext_src gtc_ext_src_inst [2:0] (
    .sys_clk(sys_clk), .rst(rst), .start(src_start), .cycles(cyc),
    .idle_hi(idle_hi), .pin(src_pin), .busy(src_busy));

  // count wake pulses
  always @(posedge sys_clk)
    if (wake_request === 1'b1)
      n_wake++;

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic set16(input logic [15:0] v);
    wr_reg(GTC_ADDR_CNT_LO, v[7:0]);
    wr_reg(GTC_ADDR_CNT_HI, v[15:8]);
  endtask

  task automatic get16(output logic [15:0] v);
    rd_reg(GTC_ADDR_CNT_LO, v[7:0]);
    rd_reg(GTC_ADDR_CNT_HI, v[15:8]);
  endtask

  // low-byte advance over exactly 64 cycles
  task automatic meas(output logic [7:0] d);
    logic [7:0] a;
    logic [7:0] b;
    rd_reg(GTC_ADDR_CNT_LO, a);
    repeat (62) @(posedge sys_clk);
    rd_reg(GTC_ADDR_CNT_LO, b);
    d = b - a;
  endtask

  task automatic burst(input int i, input logic [7:0] n);
    int k;
    k = 0;
    @(posedge sys_clk);
    cyc          <= n;
    src_start[i] <= 1'b1;
    @(posedge sys_clk);
    src_start[i] <= 1'b0;
    #1;
    while (src_busy[i] === 1'b1 && k < 200)
    begin
      @(posedge sys_clk);
      #1 k++;
    end
    if (k >= 200)
    begin
      n_fail++;
      close_out();
    end
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic t_reset();
    logic [7:0] v;
    for (int a = 5; a < 8; a++)
      wr_reg(a[2:0], 8'hff);
    for (int a = 0; a < 8; a++)
    begin
      rd_reg(a[2:0], v);
      `CHK(v, 8'h00)
    end
    `CHK(overflow_flag, 1'b0)
    `CHK(crystal_out_pin, 1'b0)
  endtask

  task automatic t_rw();
    logic [15:0] v;
    set16(16'ha55a);
    get16(v);
    `CHK(v, 16'ha55a)
  endtask

  task automatic t_rate();
    logic [7:0] d;
    logic [1:0] cs;
    for (int s = 0; s < 2; s++)
      for (int p = 0; p < 4; p++)
      begin
        cs = (s == 0) ? GTC_CS_SYS : GTC_CS_INSTR;
        wr_reg(GTC_ADDR_CTL, {cs, p[1:0], 4'h1});
        repeat (4) @(posedge sys_clk);
        meas(d);
        `CHK(d, 8'd64 >> (p + 2 * s))
      end
  endtask

  task automatic t_gate();
    logic [7:0] d;
    wr_reg(GTC_ADDR_CTL, 8'h41);
    wr_reg(GTC_ADDR_GATE, 8'h80);
    repeat (4) @(posedge sys_clk);
    meas(d);
    `CHK(d, 8'd0)
    gate_input <= 1'b1;
    repeat (4) @(posedge sys_clk);
    meas(d);
    `CHK(d, 8'd64)
    wr_reg(GTC_ADDR_GATE, 8'h00);
    gate_input <= 1'b0;
    repeat (4) @(posedge sys_clk);
    meas(d);
    `CHK(d, 8'd64)
    wr_reg(GTC_ADDR_CTL, 8'h40);
    meas(d);
    `CHK(d, 8'd0)
  endtask

  // count write must restart the divide-by-8 from zero
  task automatic t_clr();
    logic [7:0] v;
    wr_reg(GTC_ADDR_CTL, 8'h71);
    for (int k = 1; k < 8; k++)
    begin
      repeat (k) @(posedge sys_clk);
      wr_reg(GTC_ADDR_CNT_LO, 8'h00);
      repeat (2) @(posedge sys_clk);
      rd_reg(GTC_ADDR_CNT_LO, v);
      `CHK(v, 8'h00)
    end
  endtask

  task automatic t_ext();
    logic [15:0] v;
    idle_hi <= 1'b1;
    wr_reg(GTC_ADDR_CTL, 8'h81);
    repeat (4) @(posedge sys_clk);
    set16(16'h0000);
    burst(0, 8'd5);
    get16(v);
    `CHK(v, 16'h0005)
    idle_hi <= 1'b0;
    repeat (6) @(posedge sys_clk);
    set16(16'h0000);
    burst(0, 8'd3);
    get16(v);
    `CHK(v, 16'h0002)
    wr_reg(GTC_ADDR_CTL, 8'hc1);
    set16(16'h0000);
    burst(2, 8'd4);
    get16(v);
    `CHK(v, 16'h0003)
  endtask

  task automatic t_xtal();
    logic [15:0] v;
    wr_reg(GTC_ADDR_CTL, 8'h88);
    repeat (4) @(posedge sys_clk);
    `CHK(crystal_out_pin, 1'b1)
    rd_reg(GTC_ADDR_STAT, v[7:0]);
    `CHK(v[7:0], 8'h02)
    repeat (20) @(posedge sys_clk);
    set16(16'h0000);
    wr_reg(GTC_ADDR_CTL, 8'h89);
    burst(1, 8'd4);
    get16(v);
    `CHK(v, 16'h0003)
    wr_reg(GTC_ADDR_CTL, 8'h00);
    repeat (2) @(posedge sys_clk);
    `CHK(crystal_out_pin, 1'b0)
  endtask

  task automatic t_sleep();
    logic [15:0] v;
    int          w0;
    sleep_mode <= 1'b1;
    wr_reg(GTC_ADDR_CTL, 8'h41);
    repeat (4) @(posedge sys_clk);
    meas(v[7:0]);
    `CHK(v[7:0], 8'd0)
    idle_hi <= 1'b1;
    wr_reg(GTC_ADDR_CTL, 8'h81);
    repeat (6) @(posedge sys_clk);
    set16(16'h0000);
    burst(0, 8'd3);
    get16(v);
    `CHK(v, 16'h0000)
    wr_reg(GTC_ADDR_CTL, 8'h85);
    set16(16'hfffe);
    w0 = n_wake;
    burst(0, 8'd3);
    get16(v);
    `CHK(v, 16'h0001)
    `CHK(n_wake - w0, 1)
    sleep_mode <= 1'b0;
    wr_reg(GTC_ADDR_CTL, 8'h00);
    repeat (10) @(posedge sys_clk);
    `CHK(overflow_flag, 1'b1)
    wr_reg(GTC_ADDR_STAT, 8'h01);
    rd_reg(GTC_ADDR_STAT, v[7:0]);
    `CHK(v[7:0], 8'h00)
    `CHK(overflow_flag, 1'b0)
  endtask

  // main sequence
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_rw();
    t_rate();
    t_gate();
    t_clr();
    t_ext();
    t_xtal();
    t_sleep();
    close_out();
  end
endmodule
`default_nettype wire
